/* File: include/acs_defs.svh */
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// Register byte offsets
`define ACS_OFF_CTRL      8'h00
`define ACS_OFF_SELECT    8'h04
`define ACS_OFF_STATUS    8'h08
`define ACS_OFF_RESULT    8'h0c
`define ACS_OFF_SLEEP     8'h10
// Control fields
`define ACS_CTRL_EN       0
`define ACS_CTRL_START    1
`define ACS_CTRL_AUTO     2
`define ACS_CTRL_DONE     3
`define ACS_CTRL_IE       4
`define ACS_CTRL_FREE     5
`define ACS_CTRL_DIFF     6
`define ACS_CTRL_PS_LO    8
`define ACS_PS_W          3
// Select fields
`define ACS_CH_W          5
`define ACS_REF_LO        5
`define ACS_REF_W         2
// Timing in half converter cycles
`define ACS_H_FIRST_TOTAL 8'd50
`define ACS_H_NORM_TOTAL  8'd26
`define ACS_H_AUTO_TOTAL  8'd27
`define ACS_H_DIFF_TOTAL  8'd28
`define ACS_H_FIRST_SH    8'd29
`define ACS_H_NORM_SH     8'd3
`define ACS_H_AUTO_SH     8'd4
`define ACS_H_DIFF_SH     8'd5
`define ACS_FULL_SCALE    10'h3ff
`define ACS_RESET_WORD    32'h00000000
`endif

/* File: include/acs_pkg.sv */
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_ALIGN = 3'b010,
    ACS_RUN  = 3'b100
  } acs_state_e;
  typedef struct packed {
    logic [1:0] reference_select;
    logic [4:0] channel_select;
  } acs_sel_s;
  typedef struct packed {
    logic       sample_hold;
    logic       conv_active;
    acs_sel_s   sel;
  } acs_core_s;
endpackage

/* File: src/acs_sequencer.sv */
`timescale 1ns/10ps
`include "acs_defs.svh"
module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [7:0]    haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Trigger and sleep inputs from pins
  input  wire logic          trigger_in,
  input  wire logic          cpu_halted,
  // Analog core
  input  wire logic [9:0]    core_result,
  input  wire logic          core_over_ref,
  output acs_pkg::acs_core_s core_ctrl,
  output logic               half_rate_phase_clock,
  // Completion request
  output logic               done_irq_req
);
  import acs_pkg::*;

  logic              en_reg, start_reg, auto_reg, done_reg, ie_reg, free_reg, diff_reg;
  logic [2:0]        ps_sel_reg;
  acs_sel_s          temp_sel_reg, act_sel_reg;
  logic [9:0]        result_reg;
  logic [1:0]        sleep_mode_reg;
  logic              first_reg, phase_reg, half_reg, auto_conv_reg, sleep_conv_reg;
  logic [7:0]        hcnt_reg, total_reg, sh_reg;
  logic [7:0]        ps_cnt_reg;
  acs_state_e        state_reg;
  logic [2:0]        trig_sync_reg, halt_sync_reg;
  logic              sh_reg_out, irq_reg;
  logic              wr_pend_reg;
  logic [7:0]        wr_addr_reg;

  // AHB address phase capture
  // Only whole-word transfers are taken; other sizes are ignored
  wire        ahb_go     = hsel & hready & htrans[1] & (hsize == 3'h2);
  wire        ahb_wr     = ahb_go & hwrite;
  wire        wr_ctrl    = wr_pend_reg & (wr_addr_reg == `ACS_OFF_CTRL);
  wire        wr_sel     = wr_pend_reg & (wr_addr_reg == `ACS_OFF_SELECT);
  wire        wr_sleep   = wr_pend_reg & (wr_addr_reg == `ACS_OFF_SLEEP);

  // Prescaler tick is the converter clock
  wire [7:0]  ps_limit   = 8'(1 << ps_sel_reg) - 8'd1;
  wire        ps_tick    = en_reg & (ps_cnt_reg >= ps_limit);
  // Half-cycle step: a mid-period pulse plus the tick itself, so that
  // the 13.5-cycle triggered conversion ends exactly on its half cycle.
  // Prescale 0 has no mid point; it then steps by two on each tick,
  // which cannot show a half cycle, a limit users of that setting accept
  wire [7:0]  ps_mid     = ps_limit >> 1;
  wire        half_tick  = en_reg & (ps_limit != 8'h00) & (ps_cnt_reg == ps_mid);
  wire [7:0]  tick_step  = (ps_limit == 8'h00) ? 8'd2 : 8'd1;
  wire [7:0]  step       = ps_tick ? tick_step : (half_tick ? 8'd1 : 8'd0);
  wire        stepping   = ps_tick | half_tick;
  // Bit 0 only feeds bit 1; logic reads from bit 1 on, never the first flop
  wire        trig_sync  = trig_sync_reg[1];
  wire        trig_rise  = trig_sync & ~trig_sync_reg[2];
  wire        halt_rise  = halt_sync_reg[1] & ~halt_sync_reg[2];
  // Auto trigger only starts a conversion when idle and flag clear
  wire        auto_go    = en_reg & auto_reg & trig_rise & (state_reg == ACS_IDLE) & ~done_reg;
  // Noise-canceler start in idle or noise-reduction sleep
  wire        sleep_ok   = (sleep_mode_reg != 2'd0) & en_reg & ~auto_reg & ie_reg;
  wire        sleep_go   = sleep_ok & halt_rise & (state_reg == ACS_IDLE) & ~start_reg;
  wire        wr_start   = wr_ctrl & hwdata[`ACS_CTRL_START] & en_reg;
  wire        last_half  = (state_reg == ACS_RUN) & (hcnt_reg + 8'd2 >= total_reg);
  // Completion falls on the step that reaches the total, not one later
  wire        finish     = (state_reg == ACS_RUN) & stepping & (hcnt_reg + step >= total_reg);
  wire        free_again = finish & free_reg & auto_reg;
  wire        can_start  = (state_reg == ACS_IDLE) & start_reg & ps_tick;
  wire [9:0]  sat_result = core_over_ref & ~diff_reg ? `ACS_FULL_SCALE : core_result;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_sync_reg <= 3'h0;
      halt_sync_reg <= 3'h0;
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
    end
    else
    begin
      trig_sync_reg <= {trig_sync_reg[1:0], trigger_in};
      halt_sync_reg <= {halt_sync_reg[1:0], cpu_halted};
      wr_pend_reg   <= ahb_wr;
      wr_addr_reg   <= ahb_go ? haddr : wr_addr_reg;
    end
  end

  // Prescaler: held reset while disabled or on trigger
  // Reset on trigger gives a fixed delay from trigger edge to sampling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ps_cnt_reg <= 8'h00;
    else if (!en_reg || auto_go || ps_tick)
      ps_cnt_reg <= 8'h00;
    else
      ps_cnt_reg <= ps_cnt_reg + 8'd1;
  end

  // Half-rate phase toggles every converter clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase_reg <= 1'b0;
    else if (!en_reg)
      phase_reg <= 1'b0;
    else if (ps_tick)
      phase_reg <= ~phase_reg;
  end

  // Control and software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_reg <= 1'b0;
      auto_reg <= 1'b0;
      ie_reg <= 1'b0;
      free_reg <= 1'b0;
      diff_reg <= 1'b0;
      ps_sel_reg <= 3'h0;
      temp_sel_reg <= '0;
      sleep_mode_reg <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // Sleep never clears enable by itself
        en_reg <= hwdata[`ACS_CTRL_EN];
        auto_reg <= hwdata[`ACS_CTRL_AUTO];
        ie_reg <= hwdata[`ACS_CTRL_IE];
        free_reg <= hwdata[`ACS_CTRL_FREE];
        diff_reg <= hwdata[`ACS_CTRL_DIFF];
        ps_sel_reg <= hwdata[`ACS_CTRL_PS_LO +: `ACS_PS_W];
      end
      // Temporary copy always writable
      if (wr_sel)
        temp_sel_reg <= hwdata[6:0];
      if (wr_sleep)
        sleep_mode_reg <= hwdata[1:0];
    end
  end

  // Sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ACS_IDLE;
      start_reg <= 1'b0;
      done_reg <= 1'b0;
      first_reg <= 1'b1;
      hcnt_reg <= 8'h00;
      total_reg <= 8'h00;
      sh_reg <= 8'h00;
      half_reg <= 1'b0;
      auto_conv_reg <= 1'b0;
      sleep_conv_reg <= 1'b0;
      result_reg <= 10'h000;
      act_sel_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= 1'b0;
      // Follow the temporary copy unless locked
      if (state_reg == ACS_IDLE || last_half)
        act_sel_reg <= temp_sel_reg;
      // Done flag: set wins over software clear
      if (wr_ctrl && hwdata[`ACS_CTRL_DONE])
        done_reg <= 1'b0;
      if (!en_reg)
      begin
        state_reg <= ACS_IDLE;
        start_reg <= 1'b0;
        first_reg <= 1'b1;
        hcnt_reg <= 8'h00;
      end
      else
      begin
        if (wr_start || auto_go || sleep_go)
          start_reg <= 1'b1;
        if (auto_go)
          auto_conv_reg <= 1'b1;
        if (sleep_go)
          sleep_conv_reg <= 1'b1;
        unique case (state_reg)
          ACS_IDLE:
          begin
            // Start on next converter edge
            if (can_start)
            begin
              hcnt_reg <= 8'h00;
              half_reg <= 1'b0;
              if (first_reg)
              begin
                total_reg <= `ACS_H_FIRST_TOTAL;
                sh_reg <= `ACS_H_FIRST_SH;
              end
              else if (auto_conv_reg)
              begin
                total_reg <= `ACS_H_AUTO_TOTAL;
                sh_reg <= `ACS_H_AUTO_SH;
              end
              else if (diff_reg && phase_reg)
              begin
                total_reg <= `ACS_H_DIFF_TOTAL;
                sh_reg <= `ACS_H_DIFF_SH;
              end
              else
              begin
                total_reg <= `ACS_H_NORM_TOTAL;
                sh_reg <= `ACS_H_NORM_SH;
              end
              state_reg <= ACS_RUN;
            end
          end
          ACS_ALIGN:
            state_reg <= ACS_RUN;
          ACS_RUN:
          begin
            // Two half-cycle steps per converter clock, one double step at prescale 0
            hcnt_reg <= hcnt_reg + step;
            if (finish)
            begin
              result_reg <= sat_result;
              done_reg <= 1'b1;
              irq_reg <= ie_reg | sleep_conv_reg;
              first_reg <= 1'b0;
              auto_conv_reg <= 1'b0;
              sleep_conv_reg <= 1'b0;
              hcnt_reg <= 8'h00;
              if (free_again)
              begin
                // Restart already uses the frozen selection
                // Diff timing is taken at restart in diff mode without looking at the phase
                total_reg <= diff_reg ? `ACS_H_DIFF_TOTAL : `ACS_H_NORM_TOTAL;
                sh_reg <= diff_reg ? `ACS_H_DIFF_SH : `ACS_H_NORM_SH;
              end
              else
              begin
                start_reg <= 1'b0;
                state_reg <= ACS_IDLE;
              end
            end
          end
          default:
            state_reg <= ACS_IDLE;
        endcase
      end
    end
  end

  // Hold strobe stands for the step just before the hold instant
  // Registered so the core sees a clean strobe with no decode glitches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sh_reg_out <= 1'b0;
    else
      sh_reg_out <= (state_reg == ACS_RUN) & (hcnt_reg + 8'd1 >= sh_reg) & (hcnt_reg < sh_reg);
  end

  // Read mux
  // Address kept from the address phase; data stands through the data
  // phase since the slave never inserts wait states
  logic [7:0] rd_addr_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_addr_reg <= 8'h00;
    else if (ahb_go)
      rd_addr_reg <= haddr;
  end

  wire [31:0] rd_ctrl   = {21'h0, ps_sel_reg, 1'b0, diff_reg, free_reg, ie_reg, done_reg,
                           auto_reg, start_reg, en_reg};
  wire [31:0] rd_sel    = {25'h0, temp_sel_reg};
  wire [31:0] rd_status = {21'h0, act_sel_reg, phase_reg, first_reg, sh_reg_out,
                           state_reg == ACS_RUN};
  wire [31:0] rd_data   = (rd_addr_reg == `ACS_OFF_CTRL)   ? rd_ctrl :
                          (rd_addr_reg == `ACS_OFF_SELECT) ? rd_sel :
                          (rd_addr_reg == `ACS_OFF_STATUS) ? rd_status :
                          (rd_addr_reg == `ACS_OFF_RESULT) ? {22'h0, result_reg} :
                          (rd_addr_reg == `ACS_OFF_SLEEP)  ? {30'h0, sleep_mode_reg} :
                          `ACS_RESET_WORD;


  // Bus answers at once; no error response exists in this block
  assign hrdata                = rd_data;
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign half_rate_phase_clock = phase_reg;
  assign done_irq_req          = irq_reg;
  assign core_ctrl.sel         = act_sel_reg;
  assign core_ctrl.conv_active = state_reg == ACS_RUN;
  assign core_ctrl.sample_hold = sh_reg_out;
endmodule

/* File: verification/acs_core_model.sv */
`timescale 1ns/10ps
module acs_core_model
  import acs_pkg::*;
(
  // Converter side
  input  wire logic       hclk,
  input  wire acs_core_s  core_ctrl,
  // Analog stand-in
  input  wire logic [9:0] level,
  input  wire logic       over,
  output logic      [9:0] core_result,
  output logic            core_over_ref
);
  // Input held from the sampling instant on
  always_ff @(posedge hclk)
    if (core_ctrl.sample_hold)
    begin
      core_result   <= level;
      core_over_ref <= over;
    end
endmodule

/* File: verification/acs_sequencer_props.sv */
`timescale 1ns/10ps
module acs_sequencer_props
  import acs_pkg::*;
(
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Core
  input wire acs_core_s   core_ctrl,
  input wire logic        done_irq_req
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic       rdx_reg;
  logic       seldp_reg;
  logic [6:0] selv_reg;
  wire        take = hsel && hready && htrans[1];
  wire        conv = core_ctrl.conv_active;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rdx_reg   <= 1'h0;
      seldp_reg <= 1'h0;
    end
    else
    begin
      rdx_reg   <= take && !hwrite && haddr > 8'h10;
      seldp_reg <= take && hwrite && haddr == 8'h04;
    end
  // Value only exists in the data phase
  always_ff @(posedge hclk)
    if (seldp_reg)
      selv_reg <= hwdata[6:0];
  property p_unmapped; rdx_reg |-> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pulse; done_irq_req |=> !done_irq_req; endproperty
  a_pulse: assert property (p_pulse) else $error("request too long");
  property p_cause; done_irq_req |-> $past(conv); endproperty
  a_cause: assert property (p_cause) else $error("request without conversion");
  property p_hold; core_ctrl.sample_hold |-> conv; endproperty
  a_hold: assert property (p_hold) else $error("hold outside conversion");
  property p_min; $rose(conv) |-> conv[*8]; endproperty
  a_min: assert property (p_min) else $error("conversion too short");
  property p_end; $rose(conv) |-> ##[24:60] (!conv || done_irq_req); endproperty
  a_end: assert property (p_end) else $error("conversion too long");
  property p_frozen; $rose(conv) |=> $stable(core_ctrl.sel)[*8]; endproperty
  a_frozen: assert property (p_frozen) else $error("selection moved");
  property p_follow; seldp_reg ##1 !conv[*3] |-> core_ctrl.sel == selv_reg; endproperty
  a_follow: assert property (p_follow) else $error("selection not copied");
  c_done: cover property (done_irq_req);
  c_unmapped: cover property (rdx_reg);
  c_hold: cover property ($rose(core_ctrl.sample_hold));
endmodule

bind acs_sequencer acs_sequencer_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .core_ctrl(core_ctrl), .done_irq_req(done_irq_req)
);

/* File: verification/acs_sequencer_tb.sv */
`timescale 1ns/10ps
module acs_sequencer_tb;
  import acs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, trigger_in, cpu_halted;
  logic        phase, done_irq_req, core_over_ref, over, free, rd_dp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, seed;
  logic [9:0]  level, core_result;
  acs_core_s   core_ctrl;
  int          failures, n_checks, run, gap, irq_n, fcnt, n0, i;
  logic [63:0] wq[$];
  int          lq[$];
  acs_sequencer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in),
    .cpu_halted(cpu_halted), .core_result(core_result), .core_over_ref(core_over_ref),
    .core_ctrl(core_ctrl), .half_rate_phase_clock(phase), .done_irq_req(done_irq_req)
  );
  acs_core_model u_core (
    .hclk(hclk), .core_ctrl(core_ctrl), .level(level), .over(over),
    .core_result(core_result), .core_over_ref(core_over_ref)
  );
  initial
  begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task report_and_stop;
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_checks++;
    if ((got & m) !== (exp & m))
    begin
      failures++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_len(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      failures++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wq.push_back({m, e});
    bus(1'h0, a, 32'h0);
  endtask
  // Trigger kinds: 0 software, 1 pin, 2 sleep
  task go(input logic [31:0] c, input int e, input int t);
    lq.push_back(e);
    i = 0;
    wr(8'h00, c);
    trigger_in <= (t == 1);
    cpu_halted <= (t == 2);
    while (core_ctrl.conv_active !== 1'h1 && i < 99)
    begin
      @(posedge hclk);
      i++;
    end
    rdx(8'h00, 32'h2, 32'h2);
    seed = xs(seed);
    wr(8'h04, {25'h0, seed[6:0]});
    while (core_ctrl.conv_active !== 1'h0 && i < 999)
    begin
      @(posedge hclk);
      i++;
    end
    rdx(8'h04, {25'h0, seed[6:0]}, 32'h7f);
  endtask
  always @(posedge hclk)
  begin
    if (rd_dp)
      chk_word(hrdata, wq[0][31:0], wq[0][63:32]);
    if (rd_dp)
      wq.delete(0);
    rd_dp <= hsel && htrans[1] && !hwrite;
    run <= core_ctrl.conv_active === 1'h1 ? run + 1 : 0;
    if (core_ctrl.conv_active === 1'h0 && run > 0 && !free)
      chk_len(run, lq.pop_front());
    gap <= done_irq_req ? 1 : gap + 1;
    if (done_irq_req === 1'h1)
      irq_n <= irq_n + 1;
    if (done_irq_req === 1'h1 && free)
      fcnt <= fcnt + 1;
    if (done_irq_req === 1'h1 && free && fcnt > 0)
      chk_len(gap, 28);
  end
  initial
  begin
    {hsel, hwrite, trigger_in, cpu_halted, over, free, rd_dp} = 7'h0;
    {haddr, htrans, hsize, hwdata, level} = {8'h0, 2'h0, 3'h2, 32'h0, 10'h0};
    {run, gap, irq_n, fcnt, failures, n_checks} = '0;
    seed = 32'h4032;
    hresetn = 1'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    for (int a = 0; a < 24; a += 4)
      rdx(a[7:0], (a == 8) ? 32'h4 : 32'h0, 32'hffffffff);
    wr(8'h00, 32'h2);
    rdx(8'h00, 32'h0, 32'h2);
    wr(8'h00, 32'h111);
    seed = xs(seed);
    level <= seed[25:16];
    wr(8'h04, {25'h0, seed[6:0]});
    go(32'h113, 50, 0);
    rdx(8'h0c, {22'h0, level}, 32'h3ff);
    over <= 1'h1;
    go(32'h11b, 26, 0);
    rdx(8'h0c, 32'h3ff, 32'h3ff);
    over <= 1'h0;
    go(32'h11d, 27, 1);
    free <= 1'h1;
    n0 = irq_n;
    wr(8'h00, 32'h17f);
    for (i = 0; irq_n < n0 + 4 && i < 999; i++)
      @(posedge hclk);
    repeat (8) @(posedge hclk);
    wr(8'h00, 32'h0);
    repeat (4) @(posedge hclk);
    chk_word({31'h0, phase}, 32'h0, 32'h1);
    chk_word({31'h0, hresp}, 32'h0, 32'h1);
    free <= 1'h0;
    wr(8'h10, 32'h1);
    n0 = irq_n;
    go(32'h119, 50, 2);
    repeat (4) @(posedge hclk);
    chk_len(irq_n - n0, 1);
    chk_len(lq.size(), 0);
    report_and_stop();
  end
  // Whole run is a few hundred cycles
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
